// file: src/i2c_link_pkg.sv
// Shared constants and types for the two-wire register access link
// Operation
// - Work at any bus rate up to 400kHz
// - Every byte is followed by an acknowledge
// - Controller may probe with address only
// - Write: address, pointer, two or more data
// - In writes target drives only acknowledge slots
// - Read: pointer write, repeated start, read address
// - Target drives data from address acknowledge onward
// - Controller ends read with no-acknowledge, target releases
// - Write bytes land at consecutive locations
// - Pointer increments right after each byte's LSB
// - Writes beyond location 4Fh are discarded
// - Commit register only when both bytes arrive
// - Writes to read-only locations are discarded
// - Cut-short or unacknowledged bytes change nothing
// - Controller ends write with stop or restart
// - Controller reads both register bytes together
// - Read starts MSB first at pointer, then consecutive
// - Reads beyond location FFh return FFh
// - Reserved locations read as undefined data
// - Answer only the fixed bus address 36h
// - Register MSB at even, LSB at odd
package i2c_link_pkg;
	// ****************************************
	// Addresses and map bounds
	// ****************************************
	localparam logic [6:0] TARGET_BUS_ADDRESS = 7'h36;
	localparam logic [7:0] WR_TOP = 8'h4F;
	localparam logic [7:0] PAST_END_FILL = 8'hFF;
	localparam logic [7:0] RESERVED_FILL = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int PAIR_COUNT = 40;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int BUS_PERIOD_NS = 2500;
	localparam int SCL_QTR_CYC = (BUS_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	// ****************************************
	// Controller commands
	// ****************************************
	typedef enum logic [1:0] {CMD_PROBE, CMD_WRITE, CMD_READ} host_cmd_t;
endpackage : i2c_link_pkg

// file: src/i2c_link_if.sv
// Open-drain two-wire link joining controller and target
`timescale 1ns/1ns
interface i2c_link_if;
	logic scl_out;
	logic scl_oe_n;
	logic sda_h_out;
	logic sda_h_oe_n;
	logic sda_t_out;
	logic sda_t_oe_n;
	wire scl;
	wire sda;
	// Released lines float high through the pullup
	assign scl = scl_oe_n | scl_out;
	assign sda = (sda_h_oe_n | sda_h_out) & (sda_t_oe_n | sda_t_out);
	modport target (input scl, input sda, output sda_t_out, output sda_t_oe_n);
	modport ctrl (input sda, output scl_out, output scl_oe_n, output sda_h_out, output sda_h_oe_n);
endinterface : i2c_link_if

// file: src/i2c_sync2.sv
// Two-flop synchroniser for pins from another clock domain
`timescale 1ns/1ns
module i2c_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Data
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : i2c_sync2

// file: src/i2c_target_end.sv
// Target end: bus address match, pointer, register store and readback
`timescale 1ns/1ns
module i2c_target_end
	import i2c_link_pkg::*;
#(
	parameter logic [63:0] RO_PAIRS = 64'h0000_0000_0000_000F
) (
	// Link clock and reset
	input wire logic i_link_clk,
	input wire logic i_sys_rst,
	// Bus pins
	i2c_link_if.target link,
	// Gauge side update of stored registers
	input wire logic i_upd_valid,
	input wire logic [5:0] i_upd_pair,
	input wire logic [15:0] i_upd_data,
	// Committed register writes
	output logic o_commit,
	output logic [7:0] o_commit_addr,
	output logic [15:0] o_commit_data
);
	typedef enum logic [3:0] {
		T_IDLE, T_ADDR, T_ACK_ADDR, T_PTR, T_ACK_PTR, T_WDATA, T_ACK_W, T_RDATA, T_ACK_R
	} tgt_state_t;

	// ****************************************
	// Pin sampling and bus events
	// ****************************************
	logic scl_s;
	logic sda_s;
	logic scl_q;
	logic sda_q;
	logic start_c;
	logic stop_c;
	logic rise;
	logic fall;

	i2c_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
		.i_clk(i_link_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({link.scl, link.sda}),
		.o_sync({scl_s, sda_s})
	);

	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
	assign rise = scl_s & ~scl_q;
	assign fall = ~scl_s & scl_q;

	// ****************************************
	// Register store
	// ****************************************
	logic [7:0] mem [0:WR_TOP];
	logic [7:0] ptr;
	logic past_end;
	logic [7:0] hold;
	logic hold_ok;
	logic [7:0] wlo;
	logic [7:0] waddr;
	logic pend;
	logic commit_now;
	tgt_state_t state;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic rw;
	logic nak;
	logic byte_end;
	logic [7:0] rd_now;

	function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic pe);
		if (pe) begin
			return PAST_END_FILL;
		end else if (p <= WR_TOP) begin
			return mem[p[6:0]];
		end
		return RESERVED_FILL;
	endfunction : rd_byte

	function automatic logic can_write(input logic [7:0] p);
		return (p <= WR_TOP) && !RO_PAIRS[p[6:1]];
	endfunction : can_write

	assign byte_end = fall && (cnt == BYTE_BITS);
	assign commit_now = fall && (state == T_ACK_W) && pend;

	// Process form keeps the readback live when the store changes under a fixed pointer
	always_comb begin
		rd_now = rd_byte(ptr, past_end);
	end

	// ****************************************
	// Byte sequencer
	// ****************************************
	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= T_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			nak <= 1'b0;
			link.sda_t_oe_n <= 1'b1;
		end else if (start_c) begin
			state <= T_ADDR;
			cnt <= 4'h0;
			link.sda_t_oe_n <= 1'b1;
		end else if (stop_c) begin
			state <= T_IDLE;
			link.sda_t_oe_n <= 1'b1;
		end else begin
			case (state)
				T_ADDR, T_PTR, T_WDATA: begin
					if (rise) begin
						sh <= {sh[6:0], sda_s};
						cnt <= cnt + 4'h1;
					end else if (byte_end) begin
						cnt <= 4'h0;
						if (state != T_ADDR) begin
							link.sda_t_oe_n <= 1'b0;
							state <= (state == T_PTR) ? T_ACK_PTR : T_ACK_W;
						end else if (sh[7:1] == TARGET_BUS_ADDRESS) begin
							rw <= sh[0];
							link.sda_t_oe_n <= 1'b0;
							state <= T_ACK_ADDR;
						end else begin
							state <= T_IDLE;
						end
					end
				end
				T_ACK_ADDR: begin
					if (fall && rw) begin
						sh <= {rd_now[6:0], 1'b0};
						link.sda_t_oe_n <= rd_now[7];
						cnt <= 4'h1;
						state <= T_RDATA;
					end else if (fall) begin
						link.sda_t_oe_n <= 1'b1;
						state <= T_PTR;
					end
				end
				T_ACK_PTR, T_ACK_W: begin
					if (fall) begin
						link.sda_t_oe_n <= 1'b1;
						state <= T_WDATA;
					end
				end
				T_RDATA: begin
					if (byte_end) begin
						link.sda_t_oe_n <= 1'b1;
						state <= T_ACK_R;
					end else if (fall) begin
						link.sda_t_oe_n <= sh[7];
						sh <= {sh[6:0], 1'b0};
						cnt <= cnt + 4'h1;
					end
				end
				T_ACK_R: begin
					if (rise) begin
						nak <= sda_s;
					end else if (fall && nak) begin
						state <= T_IDLE;
					end else if (fall) begin
						sh <= {rd_now[6:0], 1'b0};
						link.sda_t_oe_n <= rd_now[7];
						cnt <= 4'h1;
						state <= T_RDATA;
					end
				end
				default: begin
					state <= T_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pointer, increments right after LSB
	// ****************************************
	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ptr <= 8'h00;
			past_end <= 1'b0;
		end else if (!start_c && !stop_c && byte_end) begin
			if (state == T_PTR) begin
				ptr <= sh;
				past_end <= 1'b0;
			end else if (state == T_WDATA || state == T_RDATA) begin
				ptr <= ptr + 8'h01;
				past_end <= past_end | (ptr == 8'hFF);
			end
		end
	end

	// ****************************************
	// Write pairing, committed after acknowledge
	// ****************************************
	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hold <= 8'h00;
			hold_ok <= 1'b0;
			wlo <= 8'h00;
			waddr <= 8'h00;
			pend <= 1'b0;
		end else if (start_c || stop_c) begin
			hold_ok <= 1'b0;
			pend <= 1'b0;
		end else if (byte_end && state == T_WDATA) begin
			if (!ptr[0]) begin
				hold <= sh;
				hold_ok <= !past_end && can_write(ptr);
				pend <= 1'b0;
			end else begin
				wlo <= sh;
				waddr <= {ptr[7:1], 1'b0};
				pend <= hold_ok && !past_end && can_write(ptr);
				hold_ok <= 1'b0;
			end
		end else if (commit_now) begin
			pend <= 1'b0;
		end
	end

	// Bus commit wins over a same-cycle gauge update
	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i <= int'(WR_TOP); i++) begin
				mem[i] <= 8'h00;
			end
		end else if (commit_now) begin
			mem[waddr[6:0]] <= hold;
			mem[waddr[6:0] + 7'h01] <= wlo;
		end else if (i_upd_valid && (int'(i_upd_pair) < PAIR_COUNT)) begin
			mem[{i_upd_pair, 1'b0}] <= i_upd_data[15:8];
			mem[{i_upd_pair, 1'b1}] <= i_upd_data[7:0];
		end
	end

	always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_commit <= 1'b0;
			o_commit_addr <= 8'h00;
			o_commit_data <= 16'h0000;
			link.sda_t_out <= 1'b0;
		end else begin
			o_commit <= commit_now;
			link.sda_t_out <= 1'b0;
			if (commit_now) begin
				o_commit_addr <= waddr;
				o_commit_data <= {hold, wlo};
			end
		end
	end
endmodule : i2c_target_end

// file: src/i2c_ctrl_end.sv
// Controller end: clock divider and transaction sequencer
`timescale 1ns/1ns
module i2c_ctrl_end
	import i2c_link_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Bus pins
	i2c_link_if.ctrl link,
	// Command
	input wire logic i_go,
	input wire host_cmd_t i_cmd,
	input wire logic [7:0] i_ptr,
	input wire logic [15:0] i_wdata,
	// Result
	output logic o_busy,
	output logic o_done,
	output logic o_nak,
	output logic [15:0] o_rdata
);
	typedef enum logic [2:0] {C_IDLE, C_START, C_TX, C_RX, C_RSTART, C_STOP} ctl_state_t;

	localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);

	ctl_state_t state;
	host_cmd_t cmd;
	logic [7:0] qcnt;
	logic [1:0] qtr;
	logic [3:0] bitn;
	logic [2:0] idx;
	logic [7:0] sh;
	logic [7:0] ptr;
	logic [15:0] wdata;
	logic ackbit;
	logic sda_s;
	logic tick;
	logic bit_rel;
	logic scl_rel;
	logic sda_rel;

	i2c_sync2 #(.W(1), .RST_VAL(1'b1)) u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(link.sda),
		.o_sync(sda_s)
	);

	function automatic logic [7:0] tx_byte(input logic [2:0] n);
		case (n)
			3'h0: return {TARGET_BUS_ADDRESS, 1'b0};
			3'h1: return ptr;
			3'h2: return (cmd == CMD_READ) ? {TARGET_BUS_ADDRESS, 1'b1} : wdata[15:8];
			default: return wdata[7:0];
		endcase
	endfunction : tx_byte

	// ****************************************
	// Quarter-bit divider, fixed rate
	// ****************************************
	assign tick = (qcnt == QTR_LAST);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			qcnt <= 8'h00;
		end else if (state == C_IDLE || tick) begin
			qcnt <= 8'h00;
		end else begin
			qcnt <= qcnt + 8'h01;
		end
	end

	// ****************************************
	// Pin shapes per symbol
	// ****************************************
	always_comb begin
		bit_rel = (state == C_TX) ? ((bitn < BYTE_BITS) ? sh[7] : 1'b1)
			: ((bitn < BYTE_BITS) ? 1'b1 : (idx == 3'h4));
		case (state)
			C_START: begin
				scl_rel = (qtr != 2'h3);
				sda_rel = (qtr == 2'h0);
			end
			C_RSTART: begin
				scl_rel = (qtr == 2'h1) || (qtr == 2'h2);
				sda_rel = (qtr < 2'h2);
			end
			C_STOP: begin
				scl_rel = (qtr != 2'h0);
				sda_rel = (qtr >= 2'h2);
			end
			C_TX, C_RX: begin
				scl_rel = (qtr == 2'h1) || (qtr == 2'h2);
				sda_rel = bit_rel;
			end
			default: begin
				scl_rel = 1'b1;
				sda_rel = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			link.scl_oe_n <= 1'b1;
			link.sda_h_oe_n <= 1'b1;
			link.scl_out <= 1'b0;
			link.sda_h_out <= 1'b0;
		end else begin
			link.scl_oe_n <= scl_rel;
			link.sda_h_oe_n <= sda_rel;
			link.scl_out <= 1'b0;
			link.sda_h_out <= 1'b0;
		end
	end

	// ****************************************
	// Transaction sequencer
	// ****************************************
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= C_IDLE;
			cmd <= CMD_PROBE;
			qtr <= 2'h0;
			bitn <= 4'h0;
			idx <= 3'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			wdata <= 16'h0000;
			ackbit <= 1'b1;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_nak <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			if (state == C_IDLE) begin
				qtr <= 2'h0;
				if (i_go) begin
					cmd <= i_cmd;
					ptr <= i_ptr;
					wdata <= i_wdata;
					idx <= 3'h0;
					o_nak <= 1'b0;
					o_busy <= 1'b1;
					state <= C_START;
				end
			end else if (tick) begin
				qtr <= qtr + 2'h1;
				if (qtr == 2'h1 && state == C_TX && bitn == BYTE_BITS) begin
					ackbit <= sda_s;
				end else if (qtr == 2'h1 && state == C_RX && bitn < BYTE_BITS) begin
					sh <= {sh[6:0], sda_s};
				end
				if (qtr == 2'h3) begin
					bitn <= bitn + 4'h1;
					case (state)
						C_START, C_RSTART: begin
							sh <= tx_byte(idx);
							bitn <= 4'h0;
							state <= C_TX;
						end
						C_TX: begin
							if (bitn < BYTE_BITS) begin
								sh <= {sh[6:0], 1'b0};
							end else if (ackbit) begin
								o_nak <= 1'b1;
								state <= C_STOP;
							end else if (cmd == CMD_PROBE) begin
								state <= C_STOP;
							end else if (cmd == CMD_WRITE && idx == 3'h3) begin
								state <= C_STOP;
							end else if (cmd == CMD_READ && idx == 3'h1) begin
								idx <= 3'h2;
								state <= C_RSTART;
							end else if (cmd == CMD_READ && idx == 3'h2) begin
								idx <= 3'h3;
								bitn <= 4'h0;
								state <= C_RX;
							end else begin
								idx <= idx + 3'h1;
								sh <= tx_byte(idx + 3'h1);
								bitn <= 4'h0;
							end
						end
						C_RX: begin
							if (bitn == BYTE_BITS && idx == 3'h3) begin
								o_rdata[15:8] <= sh;
								idx <= 3'h4;
								bitn <= 4'h0;
							end else if (bitn == BYTE_BITS) begin
								o_rdata[7:0] <= sh;
								state <= C_STOP;
							end
						end
						C_STOP: begin
							o_busy <= 1'b0;
							o_done <= 1'b1;
							state <= C_IDLE;
						end
						default: begin
							state <= C_IDLE;
						end
					endcase
				end
			end
		end
	end
endmodule : i2c_ctrl_end

// file: dv/i2c_link_props.sv
// Concurrent checks on the two-wire link between controller and target
`timescale 1ns/1ns
module i2c_link_props (
	// Clocks and reset
	input wire logic i_clk,
	input wire logic i_link_clk,
	input wire logic i_sys_rst,
	// Link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_h_out,
	input wire logic sda_h_oe_n,
	input wire logic sda_t_out,
	input wire logic sda_t_oe_n
);
	// ****************
	// Bus clock phase counters
	// ****************
	logic [9:0] per;
	logic [9:0] lo;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Saturate so a long idle bus never wraps into a short phase
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			per <= '0;
		end else if ($rose(scl)) begin
			per <= 10'h001;
		end else if (per != 10'h3FF) begin
			per <= per + 10'h001;
		end
	end
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lo <= '0;
		end else if ($fell(scl)) begin
			lo <= 10'h001;
		end else if (lo != 10'h3FF) begin
			lo <= lo + 10'h001;
		end
	end
	// ****************
	// Properties
	// ****************
	a_bus_rate_max: assert property ($rose(scl) |-> per >= 10'h0FA)
		else $error("bus clock period shorter than 2.5 us");
	a_scl_high_min: assert property ($fell(scl) |-> per >= 10'h03C)
		else $error("bus clock high phase too short");
	a_scl_low_min: assert property ($rose(scl) |-> lo >= 10'h078)
		else $error("bus clock low phase too short");
	a_tgt_change_low: assert property ($changed(sda_t_oe_n) |-> !scl && !$past(scl, 20))
		else $error("target changed data outside the clock low phase");
	a_tgt_hold_high: assert property ($rose(scl) && !sda_t_oe_n |-> !sda_t_oe_n [*8])
		else $error("target drive dropped inside a clock high phase");
	a_stop_release: assert property (scl && $rose(sda) |-> sda_t_oe_n [*8])
		else $error("target pulls data after a stop");
	a_start_by_ctrl: assert property (scl && $fell(sda) |-> sda_t_oe_n && !sda_h_oe_n)
		else $error("start not made by the controller");
	a_open_drain: assert property (!scl_out && !sda_h_out && !sda_t_out)
		else $error("a link driver pushes a high level");
endmodule : i2c_link_props

// file: dv/i2c_register_access_slave_test.sv
// Self-checking bench for the controller and target ends
`timescale 1ns/1ns
module i2c_register_access_slave_test;
	import i2c_link_pkg::*;
	logic i_clk = 1'b0;
	logic i_link_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic go = 1'b0;
	host_cmd_t cmd = CMD_PROBE;
	logic [7:0] ptr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic upd_valid = 1'b0;
	logic [5:0] upd_pair = 6'h00;
	logic [15:0] upd_data = 16'h0000;
	logic busy;
	logic done;
	logic nak;
	logic commit;
	logic [15:0] rdata;
	logic [15:0] commit_data;
	logic [7:0] commit_addr;
	int n_fail = 0;
	int checks_done = 0;
	int n_commit = 0;
	int cyc = 0;
	i2c_link_if link ();
	i2c_link_if link2 ();
	i2c_ctrl_end i2c_ctrl_end_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link.ctrl), .i_go(go), .i_cmd(cmd),
		.i_ptr(ptr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nak(nak), .o_rdata(rdata));
	i2c_target_end i2c_target_end_i (.i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst), .link(link.target),
		.i_upd_valid(upd_valid), .i_upd_pair(upd_pair), .i_upd_data(upd_data), .o_commit(commit),
		.o_commit_addr(commit_addr), .o_commit_data(commit_data));
	// Second target faces a hand-driven controller that can break the rules
	i2c_target_end i2c_target_end_i_b (.i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst), .link(link2.target),
		.i_upd_valid(1'b0), .i_upd_pair(6'h00), .i_upd_data(16'h0000), .o_commit(), .o_commit_addr(),
		.o_commit_data());
	i2c_link_props i2c_link_props_i (.i_clk(i_clk), .i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst),
		.scl(link.scl), .sda(link.sda), .scl_out(link.scl_out), .scl_oe_n(link.scl_oe_n),
		.sda_h_out(link.sda_h_out), .sda_h_oe_n(link.sda_h_oe_n), .sda_t_out(link.sda_t_out),
		.sda_t_oe_n(link.sda_t_oe_n));
	// ****************
	// Clocks, monitor, timeout
	// ****************
	always #5 i_clk = ~i_clk;
	always #80 i_link_clk = ~i_link_clk;
	// Counted mid-cycle, away from the edge that launches the pulse
	always @(negedge i_link_clk) begin
		if (commit === 1'b1) begin
			n_commit <= n_commit + 1;
		end
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			n_fail = n_fail + 1;
			summarize();
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task summarize();
		$display("mismatches=%0d comparisons=%0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task run(input host_cmd_t c, input logic [7:0] p, input logic [15:0] d);
		int i;
		@(posedge i_clk);
		go <= 1'b1;
		cmd <= c;
		ptr <= p;
		wdata <= d;
		@(posedge i_clk);
		go <= 1'b0;
		for (i = 0; i < 13000; i++) begin
			@(posedge i_clk);
			#1;
			if (done === 1'b1) break;
		end
		check({15'h0000, done}, 16'h0001);
	endtask : run
	// Quarter of a bus clock on the hand-driven link
	task q();
		repeat (63) @(posedge i_clk);
	endtask : q
	task bb_bit(input logic b, output logic s);
		link2.sda_h_oe_n <= b;
		q();
		link2.scl_oe_n <= 1'b1;
		q();
		s = link2.sda;
		q();
		link2.scl_oe_n <= 1'b0;
		q();
	endtask : bb_bit
	task bb_addr(input logic [7:0] a, output logic ack);
		logic s;
		link2.sda_h_oe_n <= 1'b1;
		q();
		link2.scl_oe_n <= 1'b1;
		q();
		link2.sda_h_oe_n <= 1'b0;
		q();
		link2.scl_oe_n <= 1'b0;
		q();
		for (int i = 7; i >= 0; i--) begin
			bb_bit(a[i], s);
		end
		bb_bit(1'b1, ack);
	endtask : bb_addr
	// ****************
	// Scenarios
	// ****************
	task t_probe();
		run(CMD_PROBE, 8'h00, 16'h0000);
		check({15'h0000, nak}, 16'h0000);
	endtask : t_probe
	task t_write_read();
		int c;
		c = n_commit;
		run(CMD_WRITE, 8'h08, 16'h1234);
		check(n_commit[15:0], c[15:0] + 16'h0001);
		check({8'h00, commit_addr}, 16'h0008);
		check(commit_data, 16'h1234);
		check({15'h0000, busy}, 16'h0000);
		run(CMD_READ, 8'h08, 16'h0000);
		check(rdata, 16'h1234);
		check({15'h0000, nak}, 16'h0000);
	endtask : t_write_read
	task t_read_only();
		int c;
		@(posedge i_link_clk);
		upd_valid <= 1'b1;
		upd_pair <= 6'h01;
		upd_data <= 16'hABCD;
		@(posedge i_link_clk);
		upd_valid <= 1'b0;
		c = n_commit;
		run(CMD_WRITE, 8'h02, 16'h5555);
		check(n_commit[15:0], c[15:0]);
		run(CMD_READ, 8'h02, 16'h0000);
		check(rdata, 16'hABCD);
	endtask : t_read_only
	task t_top_edge();
		int c;
		c = n_commit;
		run(CMD_WRITE, 8'h4E, 16'hBEEF);
		check(n_commit[15:0], c[15:0] + 16'h0001);
		check({commit_addr, 8'h00}, 16'h4E00);
		run(CMD_WRITE, 8'h50, 16'h7777);
		check(n_commit[15:0], c[15:0] + 16'h0001);
		// Odd start drops its byte, the even one never gets a partner
		run(CMD_WRITE, 8'h09, 16'h6666);
		check(n_commit[15:0], c[15:0] + 16'h0001);
	endtask : t_top_edge
	task t_past_end();
		run(CMD_READ, 8'hFF, 16'h0000);
		check(rdata, {RESERVED_FILL, PAST_END_FILL});
	endtask : t_past_end
	task t_foreign();
		logic ack;
		bb_addr(8'h6C, ack);
		check({15'h0000, ack}, 16'h0000);
		// Foreign address behind a repeated start must not be answered
		bb_addr(8'h70, ack);
		check({15'h0000, ack}, 16'h0001);
		link2.sda_h_oe_n <= 1'b0;
		q();
		link2.scl_oe_n <= 1'b1;
		q();
		link2.sda_h_oe_n <= 1'b1;
		q();
		check({15'h0000, link2.sda_t_oe_n}, 16'h0001);
	endtask : t_foreign
	initial begin
		link2.scl_out = 1'b0;
		link2.sda_h_out = 1'b0;
		link2.scl_oe_n = 1'b1;
		link2.sda_h_oe_n = 1'b1;
		// Held over two link clock edges so the target domain resets too
		repeat (2) @(posedge i_link_clk);
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_probe();
		t_write_read();
		t_read_only();
		t_top_edge();
		t_past_end();
		t_foreign();
		summarize();
	end
endmodule : i2c_register_access_slave_test
